// ---- acsr_pkg.sv ----
// Shared constants and types for the converter control and status registers
package acsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h1D;
  localparam logic [7:0] STAT_HI_OFF = 8'h1E;
  localparam logic [7:0] STAT_LO_OFF = 8'h1F;

  // ----------------------------------------------------------------
  // Control byte fields and reset value
  // ----------------------------------------------------------------
  localparam int CTRL_REBOOT = 7;
  localparam int CTRL_CLEAR = 6;
  localparam int CTRL_FREEZE = 5;
  localparam int CTRL_SNAP_EN = 2;
  localparam int CTRL_DRIVE_LVL = 1;
  localparam int CTRL_HALT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int REBOOT_DELAY_MS = 3200;
  localparam int REBOOT_CYCLES = REBOOT_DELAY_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  // Bus address value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam int NSYNC = 12;
  // Clock and data lines idle high, so their stages reset high
  localparam logic [NSYNC-1:0] SYNC_RESET = 12'hC00;

  // ----------------------------------------------------------------
  // Meter and fault widths
  // ----------------------------------------------------------------
  localparam int ENERGY_W = 48;
  localparam int TICK_W = 32;
  localparam int SAMPLE_W = 16;
  localparam int FAULT_W = 8;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CV_IDLE = 2'h1,
    CV_RUN = 2'h2
  } acsr_conv_t;

  typedef enum logic [6:0] {
    SL_IDLE = 7'h01,
    SL_ADDR = 7'h02,
    SL_ACK_A = 7'h04,
    SL_WR = 7'h08,
    SL_ACK_W = 7'h10,
    SL_RD = 7'h20,
    SL_ACK_R = 7'h40
  } acsr_link_t;

endpackage : acsr_pkg

// ---- acsr_meter.sv ----
// Energy accumulator and tick counter with clear, freeze and wrap flags
`timescale 1ns/1ns
`default_nettype none
module acsr_meter #(
  parameter int E_W = acsr_pkg::ENERGY_W,
  parameter int T_W = acsr_pkg::TICK_W,
  parameter int S_W = acsr_pkg::SAMPLE_W
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Samples
  input wire logic sample_valid,
  input wire logic use_current,
  input wire logic [S_W-1:0] power_sample,
  input wire logic [S_W-1:0] current_sample,
  // Control
  input wire logic clear,
  input wire logic freeze,
  // Results
  output logic [E_W-1:0] energy,
  output logic [T_W-1:0] ticks,
  output logic energy_wrap,
  output logic tick_wrap
);

  wire [S_W-1:0] sample = use_current ? current_sample : power_sample;
  wire [E_W:0] e_sum = {1'b0, energy} + {{(E_W + 1 - S_W){1'b0}}, sample};
  wire [T_W:0] t_sum = {1'b0, ticks} + {{T_W{1'b0}}, 1'b1};
  wire step = sample_valid & ~freeze;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      energy <= '0;
      ticks <= '0;
      energy_wrap <= 1'b0;
      tick_wrap <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        energy <= '0;
        ticks <= '0;
        energy_wrap <= 1'b0;
        tick_wrap <= 1'b0;
      end else if (step) begin
        energy <= e_sum[E_W-1:0];
        ticks <= t_sum[T_W-1:0];
        energy_wrap <= energy_wrap | e_sum[E_W];
        tick_wrap <= tick_wrap | t_sum[T_W];
      end
    end
  end

endmodule : acsr_meter
`default_nettype wire

// ---- acsr_regs.sv ----
// Converter control and status registers behind a two-wire serial slave
//
// How it works
// - Reboot bit turns pass devices off, reloads defaults, restarts after 3.2 s.
// - Clear bit holds energy accumulator and tick counter at zero while set.
// - Freeze bit stops both counters adding while set, values kept.
// - Snapshot enable plus rising fault bit requests fault and alert log store.
// - Read-only drive level flag: 0 when either gate drive above 8 V.
// - In single-shot mode each write with bit still set runs one round.
// - With single-shot clear, conversions restart continuously without host writes.
// - Status bit 7 shows pass devices enabled: commanded on and no reboot running.
// - Degraded pass device cooldown shown while that cool-down runs.
// - Shorted pass device bit set while converter sees a short.
// - Enable pin level bit follows the present pin level.
// - Output-ok bit shows output above power-good threshold.
// - Overcurrent cooldown bit set while the cool-down interval lasts.
// - Input low and input high flags follow the under and over comparators.
// - Second status byte bits 7..4 show general pins three..one and alert pin.
// - Nonvolatile busy held high through any nonvolatile write; host waits.
// - Converter idle reads 1 only when stopped in single-shot mode.
// - Tick wrap bit set once the tick counter overflows.
// - Accumulator wrap bit set once the energy accumulator overflows.
// - Tick counter adds one per accumulated conversion cycle.
// - Accumulator adds power, or current when charge metering selected.
`timescale 1ns/1ns
`default_nettype none
module acsr_regs #(
  parameter int REBOOT_CYCLES = acsr_pkg::REBOOT_CYCLES,
  parameter logic [6:0] DEV_ADDR = acsr_pkg::DEV_ADDR,
  parameter int FAULT_W = acsr_pkg::FAULT_W,
  parameter int E_W = acsr_pkg::ENERGY_W,
  parameter int T_W = acsr_pkg::TICK_W,
  parameter int S_W = acsr_pkg::SAMPLE_W
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Two-wire serial link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe_b,
  // Asynchronous pins and comparators
  input wire logic enable_pin,
  input wire logic gen_pin3,
  input wire logic gen_pin2,
  input wire logic gen_pin1,
  input wire logic alert_pin,
  input wire logic [1:0] gate_above_8v,
  input wire logic output_above_pg,
  input wire logic input_below_uv,
  input wire logic input_above_ov,
  // Protection logic
  input wire logic pass_on_cmd,
  input wire logic degraded_pass_cooldown,
  input wire logic pass_device_shorted,
  input wire logic overcurrent_cooldown,
  input wire logic restart_cfg,
  output logic pass_enable,
  output logic nv_reload,
  output logic restart_pulse,
  // Converter
  input wire logic conv_done,
  input wire logic [S_W-1:0] power_sample,
  input wire logic [S_W-1:0] current_sample,
  input wire logic charge_meter_sel,
  output logic conv_start,
  // Fault log and nonvolatile store
  input wire logic [FAULT_W-1:0] fault_bits,
  input wire logic nv_busy,
  output logic nv_snapshot_req,
  // Meter results
  output logic [E_W-1:0] energy_value,
  output logic [T_W-1:0] tick_value
);

  // ----------------------------------------------------------------
  // Read selection, used for the current and the next pointer
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_sel(input logic [7:0] ptr, input logic [7:0] c,
                                          input logic [7:0] s1, input logic [7:0] s2);
    logic [7:0] r;
    r = 8'h00;
    if (ptr == acsr_pkg::CTRL_OFF) begin
      r = c;
    end else if (ptr == acsr_pkg::STAT_HI_OFF) begin
      r = s1;
    end else if (ptr == acsr_pkg::STAT_LO_OFF) begin
      r = s2;
    end
    return r;
  endfunction : read_sel

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [acsr_pkg::NSYNC-1:0] async_in = {scl_in, sda_in, enable_pin, gen_pin3, gen_pin2, gen_pin1,
                                        alert_pin, gate_above_8v, output_above_pg, input_below_uv,
                                        input_above_ov};
  logic [acsr_pkg::NSYNC-1:0] sync_a;
  logic [acsr_pkg::NSYNC-1:0] sync_b;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_a <= acsr_pkg::SYNC_RESET;
      sync_b <= acsr_pkg::SYNC_RESET;
    end else if (ce) begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  wire scl_s = sync_b[11];
  wire sda_s = sync_b[10];
  wire en_s = sync_b[9];
  wire [2:0] gpin_s = sync_b[8:6];
  wire alert_s = sync_b[5];
  wire [1:0] gate_s = sync_b[4:3];
  wire pg_s = sync_b[2];
  wire uv_s = sync_b[1];
  wire ov_s = sync_b[0];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic clear_bit;
  logic freeze_bit;
  logic snap_en;
  logic halt;
  logic rebooting;
  logic [31:0] reboot_cnt;
  logic snap_pending;
  logic [FAULT_W-1:0] fault_q;
  acsr_pkg::acsr_conv_t cv_state;
  logic energy_wrap;
  logic tick_wrap;
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  wire drive_level_flag = ~|gate_s;
  wire adc_idle = (cv_state == acsr_pkg::CV_IDLE) & halt;
  wire nv_busy_flag = nv_busy | snap_pending;

  wire [7:0] ctrl_rd = {rebooting, clear_bit, freeze_bit, 2'b00, snap_en, drive_level_flag, halt};
  wire [7:0] stat1 = {pass_enable, degraded_pass_cooldown, pass_device_shorted, en_s,
                      pg_s, overcurrent_cooldown, uv_s, ov_s};
  wire [7:0] stat2 = {gpin_s, alert_s, nv_busy_flag, adc_idle, tick_wrap, energy_wrap};

  // Only the control offset accepts writes; status offsets drop them
  wire ctrl_wr = wr_pulse & (wr_addr == acsr_pkg::CTRL_OFF);
  wire reboot_go = ctrl_wr & wr_data[acsr_pkg::CTRL_REBOOT] & ~rebooting;
  wire ss_trigger = ctrl_wr & wr_data[acsr_pkg::CTRL_HALT] & halt;

  // ----------------------------------------------------------------
  // Control byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clear_bit <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_CLEAR];
      freeze_bit <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_FREEZE];
      snap_en <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_SNAP_EN];
      halt <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_HALT];
    end else if (ce) begin
      if (reboot_go) begin
        clear_bit <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_CLEAR];
        freeze_bit <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_FREEZE];
        snap_en <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_SNAP_EN];
        halt <= acsr_pkg::CTRL_RESET[acsr_pkg::CTRL_HALT];
      end else if (ctrl_wr) begin
        clear_bit <= wr_data[acsr_pkg::CTRL_CLEAR];
        freeze_bit <= wr_data[acsr_pkg::CTRL_FREEZE];
        snap_en <= wr_data[acsr_pkg::CTRL_SNAP_EN];
        halt <= wr_data[acsr_pkg::CTRL_HALT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reboot sequence
  // ----------------------------------------------------------------
  wire reboot_end = rebooting & (reboot_cnt == 32'h00000000);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rebooting <= 1'b0;
      reboot_cnt <= 32'h00000000;
      nv_reload <= 1'b0;
      restart_pulse <= 1'b0;
      pass_enable <= 1'b0;
    end else if (ce) begin
      nv_reload <= reboot_go;
      restart_pulse <= reboot_end & restart_cfg;
      if (reboot_go) begin
        rebooting <= 1'b1;
        reboot_cnt <= 32'(REBOOT_CYCLES - 1);
      end else if (reboot_end) begin
        rebooting <= 1'b0;
      end else if (rebooting) begin
        reboot_cnt <= reboot_cnt - 32'h00000001;
      end
      // Pass devices are held off for the whole reboot delay
      pass_enable <= pass_on_cmd & ~rebooting & ~reboot_go;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  wire cv_go = (cv_state == acsr_pkg::CV_IDLE) & (~halt | ss_trigger) & ~rebooting;
  wire cv_again = (cv_state == acsr_pkg::CV_RUN) & conv_done & ~halt & ~rebooting;
  acsr_pkg::acsr_conv_t next_cv_state;

  always_comb begin
    next_cv_state = cv_state;
    case (cv_state)
      acsr_pkg::CV_IDLE: begin
        if (cv_go) begin
          next_cv_state = acsr_pkg::CV_RUN;
        end
      end
      acsr_pkg::CV_RUN: begin
        if (conv_done & ~cv_again) begin
          next_cv_state = acsr_pkg::CV_IDLE;
        end
      end
      default: next_cv_state = acsr_pkg::CV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cv_state <= acsr_pkg::CV_IDLE;
      conv_start <= 1'b0;
    end else if (ce) begin
      cv_state <= next_cv_state;
      conv_start <= cv_go | cv_again;
    end
  end

  // ----------------------------------------------------------------
  // Fault snapshot request
  // ----------------------------------------------------------------
  wire fault_rise = |(fault_bits & ~fault_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fault_q <= '0;
      nv_snapshot_req <= 1'b0;
      snap_pending <= 1'b0;
    end else if (ce) begin
      fault_q <= fault_bits;
      nv_snapshot_req <= fault_rise & snap_en;
      // Busy covers the gap until the store raises its own busy; a new request wins over the clear
      if (nv_snapshot_req) begin
        snap_pending <= 1'b1;
      end else if (nv_busy) begin
        snap_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Meter
  // ----------------------------------------------------------------
  acsr_meter #(.E_W(E_W), .T_W(T_W), .S_W(S_W)) u_meter (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .sample_valid(conv_done),
    .use_current(charge_meter_sel),
    .power_sample(power_sample),
    .current_sample(current_sample),
    .clear(clear_bit),
    .freeze(freeze_bit),
    .energy(energy_value),
    .ticks(tick_value),
    .energy_wrap(energy_wrap),
    .tick_wrap(tick_wrap)
  );

  // ----------------------------------------------------------------
  // Two-wire serial slave
  // ----------------------------------------------------------------
  logic scl_q;
  logic sda_q;
  acsr_pkg::acsr_link_t sl_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] ptr;
  logic first_byte;
  logic is_read;
  logic host_ack;
  logic pull_low;

  wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire [7:0] ptr_next = ptr + 8'h01;
  // Status is sampled here, at the fall that starts the byte
  wire [7:0] rd_now = read_sel(ptr, ctrl_rd, stat1, stat2);
  wire [7:0] rd_next = read_sel(ptr_next, ctrl_rd, stat1, stat2);
  wire addr_hit = (shift_in[7:1] == DEV_ADDR);

  assign sda_o = 1'b0;
  assign sda_oe_b = ~pull_low;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sl_state <= acsr_pkg::SL_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      ptr <= 8'h00;
      first_byte <= 1'b0;
      is_read <= 1'b0;
      host_ack <= 1'b0;
      pull_low <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_pulse <= 1'b0;
      if (start_cond) begin
        sl_state <= acsr_pkg::SL_ADDR;
        bit_cnt <= 4'h0;
        pull_low <= 1'b0;
      end else if (stop_cond) begin
        sl_state <= acsr_pkg::SL_IDLE;
        pull_low <= 1'b0;
      end else if (scl_rise) begin
        if ((sl_state == acsr_pkg::SL_ADDR) || (sl_state == acsr_pkg::SL_WR)) begin
          shift_in <= {shift_in[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (sl_state == acsr_pkg::SL_ACK_R) begin
          host_ack <= ~sda_s;
        end
      end else if (scl_fall) begin
        case (sl_state)
          acsr_pkg::SL_ADDR: begin
            if (bit_cnt == 4'h8) begin
              if (addr_hit) begin
                sl_state <= acsr_pkg::SL_ACK_A;
                is_read <= shift_in[0];
                pull_low <= 1'b1;
              end else begin
                sl_state <= acsr_pkg::SL_IDLE;
              end
            end
          end
          acsr_pkg::SL_ACK_A: begin
            bit_cnt <= 4'h0;
            if (is_read) begin
              sl_state <= acsr_pkg::SL_RD;
              pull_low <= ~rd_now[7];
              shift_out <= {rd_now[6:0], 1'b1};
              bit_cnt <= 4'h1;
            end else begin
              sl_state <= acsr_pkg::SL_WR;
              first_byte <= 1'b1;
              pull_low <= 1'b0;
            end
          end
          acsr_pkg::SL_WR: begin
            if (bit_cnt == 4'h8) begin
              sl_state <= acsr_pkg::SL_ACK_W;
              pull_low <= 1'b1;
              first_byte <= 1'b0;
              if (first_byte) begin
                ptr <= shift_in;
              end else begin
                wr_pulse <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shift_in;
                ptr <= ptr_next;
              end
            end
          end
          acsr_pkg::SL_ACK_W: begin
            sl_state <= acsr_pkg::SL_WR;
            bit_cnt <= 4'h0;
            pull_low <= 1'b0;
          end
          acsr_pkg::SL_RD: begin
            if (bit_cnt == 4'h8) begin
              sl_state <= acsr_pkg::SL_ACK_R;
              pull_low <= 1'b0;
            end else begin
              pull_low <= ~shift_out[7];
              shift_out <= {shift_out[6:0], 1'b1};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          acsr_pkg::SL_ACK_R: begin
            if (host_ack) begin
              sl_state <= acsr_pkg::SL_RD;
              ptr <= ptr_next;
              pull_low <= ~rd_next[7];
              shift_out <= {rd_next[6:0], 1'b1};
              bit_cnt <= 4'h1;
            end else begin
              sl_state <= acsr_pkg::SL_IDLE;
              pull_low <= 1'b0;
            end
          end
          default: begin
            pull_low <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : acsr_regs
`default_nettype wire

// ---- acsr_props.sv ----
// Checker for the converter control and status registers
`timescale 1ns/1ns
`default_nettype none
module acsr_props #(
  parameter int E_W = acsr_pkg::ENERGY_W,
  parameter int T_W = acsr_pkg::TICK_W,
  parameter int S_W = acsr_pkg::SAMPLE_W,
  parameter int FAULT_W = acsr_pkg::FAULT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic pass_on_cmd,
  input wire logic restart_cfg,
  input wire logic pass_enable,
  input wire logic nv_reload,
  input wire logic restart_pulse,
  input wire logic conv_done,
  input wire logic [S_W-1:0] power_sample,
  input wire logic [S_W-1:0] current_sample,
  input wire logic charge_meter_sel,
  input wire logic conv_start,
  input wire logic [FAULT_W-1:0] fault_bits,
  input wire logic nv_snapshot_req,
  input wire logic [E_W-1:0] energy_value,
  input wire logic [T_W-1:0] tick_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_reload_off;
    nv_reload |=> (!pass_enable && !nv_reload) [*8];
  endproperty
  a_reload_off: assert property (p_reload_off) else $error("pass enable during reboot");
  property p_restart_cfg;
    restart_pulse |-> $past(restart_cfg);
  endproperty
  a_restart_cfg: assert property (p_restart_cfg) else $error("restart not configured");
  property p_on_follow;
    pass_enable |-> $past(pass_on_cmd);
  endproperty
  a_on_follow: assert property (p_on_follow) else $error("pass enable without command");
  property p_snap_cause;
    nv_snapshot_req |-> ($past(fault_bits) & ~$past(fault_bits, 2)) != '0;
  endproperty
  a_snap_cause: assert property (p_snap_cause) else $error("snapshot without fault rise");
  property p_snap_pulse;
    nv_snapshot_req |=> !nv_snapshot_req || (($past(fault_bits) & ~$past(fault_bits, 2)) != '0);
  endproperty
  a_snap_pulse: assert property (p_snap_pulse) else $error("snapshot request too long");
  property p_tick_step;
    (tick_value != $past(tick_value)) && (tick_value != '0)
      |-> (tick_value == $past(tick_value) + T_W'(1)) && $past(conv_done);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("tick step wrong");
  property p_energy_step;
    (energy_value != $past(energy_value)) && (energy_value != '0) |-> energy_value == $past(energy_value)
      + E_W'($past(charge_meter_sel) ? $past(current_sample) : $past(power_sample));
  endproperty
  a_energy_step: assert property (p_energy_step) else $error("energy step wrong");
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  c_reload: cover property (nv_reload);
  c_restart: cover property (restart_pulse);
  c_snap: cover property (nv_snapshot_req);
  c_start: cover property (conv_start);
endmodule : acsr_props

bind acsr_regs acsr_props #(.E_W(E_W), .T_W(T_W), .S_W(S_W), .FAULT_W(FAULT_W)) i_acsr_props (
  .clk(clk), .rst_b(rst_b), .pass_on_cmd(pass_on_cmd), .restart_cfg(restart_cfg),
  .pass_enable(pass_enable), .nv_reload(nv_reload), .restart_pulse(restart_pulse),
  .conv_done(conv_done), .power_sample(power_sample), .current_sample(current_sample),
  .charge_meter_sel(charge_meter_sel), .conv_start(conv_start), .fault_bits(fault_bits),
  .nv_snapshot_req(nv_snapshot_req), .energy_value(energy_value), .tick_value(tick_value));
`default_nettype wire

// ---- acsr_host.sv ----
// Two-wire bus host model for the register block
`timescale 1ns/1ns
`default_nettype none
module acsr_host #(
  parameter logic [6:0] ADDR = acsr_pkg::DEV_ADDR
) (
  // Clock
  input wire logic clk,
  // Serial link
  input wire logic sda_o,
  input wire logic sda_oe_b,
  output logic scl,
  output logic sda
);
  logic scl_r = 1'b1;
  logic sda_r = 1'b1;
  logic [7:0] junk;
  // Pulled-up line: high unless a party pulls it low
  assign scl = scl_r;
  assign sda = sda_r & (sda_oe_b | sda_o);
  // Quarter bit of 8 clocks keeps clock low well above the sync delay
  task automatic q;
    repeat (8) @(posedge clk);
  endtask : q
  task automatic bit_io(input logic b, output logic r);
    scl_r <= 1'b0;
    q();
    sda_r <= b;
    q();
    scl_r <= 1'b1;
    q();
    r = sda;
    q();
  endtask : bit_io
  task automatic start;
    scl_r <= 1'b0;
    q();
    sda_r <= 1'b1;
    q();
    scl_r <= 1'b1;
    q();
    sda_r <= 1'b0;
    q();
  endtask : start
  task automatic stop;
    scl_r <= 1'b0;
    q();
    sda_r <= 1'b0;
    q();
    scl_r <= 1'b1;
    q();
    sda_r <= 1'b1;
    q();
  endtask : stop
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(a, ack);
  endtask : byte_io
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic a0, a1, a2;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, junk, a0);
    byte_io(p, 1'b1, junk, a1);
    byte_io(d, 1'b1, junk, a2);
    stop();
    nak = a0 | a1 | a2;
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic nak);
    logic a0, a1, a2, a3;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, junk, a0);
    byte_io(p, 1'b1, junk, a1);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, junk, a2);
    byte_io(8'hFF, 1'b1, d, a3);
    stop();
    nak = a0 | a1 | a2;
  endtask : rd
endmodule : acsr_host
`default_nettype wire

// ---- tb_adc_control_status_regs.sv ----
// Self-checking bench for the converter control and status registers
`timescale 1ns/1ns
`default_nettype none
module tb_adc_control_status_regs;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] pat = 8'h00;
  logic [7:0] fault = 8'h00;
  logic [1:0] gate = 2'b00;
  logic sel = 1'b0;
  logic nvb = 1'b0;
  logic cdone = 1'b0;
  logic rcfg = 1'b1;
  logic scl, sda, sda_o, sda_oe_b, conv_start, snap, reload, restart, pass_enable;
  logic [47:0] energy_value;
  logic [31:0] tick_value;
  logic [7:0] pats [2] = '{8'hA5, 8'h5A};
  int cwait = 0, nvw = 0, n_start = 0, n_snap = 0, n_reload = 0, n_restart = 0;
  int errors = 0, compares = 0, k, c;
  logic [47:0] t;
  always #20 clk = ~clk;
  acsr_regs #(.REBOOT_CYCLES(20)) i_acsr_regs (.clk(clk), .rst_b(rst_b), .ce(1'b1), .scl_in(scl),
    .sda_in(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .enable_pin(pat[4]), .gen_pin3(pat[7]),
    .gen_pin2(pat[6]), .gen_pin1(pat[5]), .alert_pin(pat[4]), .gate_above_8v(gate),
    .output_above_pg(pat[3]), .input_below_uv(pat[1]), .input_above_ov(pat[0]), .pass_on_cmd(pat[7]),
    .degraded_pass_cooldown(pat[6]), .pass_device_shorted(pat[5]), .overcurrent_cooldown(pat[2]),
    .restart_cfg(rcfg), .pass_enable(pass_enable), .nv_reload(reload), .restart_pulse(restart),
    .conv_done(cdone), .power_sample(16'h0010), .current_sample(16'h0003), .charge_meter_sel(sel),
    .conv_start(conv_start), .fault_bits(fault), .nv_busy(nvb), .nv_snapshot_req(snap),
    .energy_value(energy_value), .tick_value(tick_value));
  acsr_host i_acsr_host (.clk(clk), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .scl(scl), .sda(sda));
  // Converter rounds of 5 clocks and a long nonvolatile write
  always @(posedge clk) begin
    cdone <= (cwait == 1);
    cwait <= conv_start ? 5 : (cwait > 0 ? cwait - 1 : 0);
    nvw <= snap ? 3000 : (nvw > 0 ? nvw - 1 : 0);
    nvb <= (nvw > 1);
    n_start <= n_start + int'(conv_start);
    n_snap <= n_snap + int'(snap);
    n_reload <= n_reload + int'(reload);
    n_restart <= n_restart + int'(restart);
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr8(input logic [7:0] p, input logic [7:0] d);
    logic nak;
    i_acsr_host.wr(p, d, nak);
    chk(nak, 1'b0);
  endtask : wr8
  task automatic rd8(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic nak;
    i_acsr_host.rd(p, d, nak);
    chk({nak, d}, {1'b0, e});
  endtask : rd8
  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      errors++;
      end_sim();
    end
  endtask : lim
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd8(8'h1D, 8'h02);
    gate <= 2'b01;
    wr8(8'h1D, 8'h1E);
    wr8(8'h3F, 8'hFF);
    rd8(8'h1D, 8'h04);
    for (int i = 0; i < 2; i++) begin
      pat <= pats[i];
      rd8(8'h1E, pats[i]);
      rd8(8'h1F, {pats[i][7:4], 4'h0});
    end
    wr8(8'h1E, 8'h00);
    rd8(8'h1E, 8'h5A);
    pat <= 8'h00;
    fault <= 8'h10;
    rd8(8'h1F, 8'h08);
    chk(n_snap, 1);
    for (k = 0; k < 4000 && nvb; k++) @(posedge clk);
    lim(k, 4000);
    rd8(8'h1F, 8'h00);
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      wr8(8'h1D, 8'h44);
      @(negedge clk);
      chk(tick_value, 48'h0);
      chk(energy_value, 48'h0);
      wr8(8'h1D, 8'h04);
      wr8(8'h1D, 8'h24);
      @(negedge clk);
      t = 48'(tick_value);
      chk(energy_value, t * (s ? 48'h3 : 48'h10));
      chk(t != 0, 1'b1);
      rd8(8'h1D, 8'h24);
      chk(tick_value, t);
    end
    wr8(8'h1D, 8'h05);
    rd8(8'h1F, 8'h04);
    c = n_start;
    wr8(8'h1D, 8'h05);
    rd8(8'h1F, 8'h04);
    chk(n_start - c, 1);
    wr8(8'h1D, 8'h04);
    c = n_start;
    rd8(8'h1F, 8'h00);
    chk(n_start > c + 10, 1'b1);
    // Pass devices commanded on, so the reboot must visibly switch them off
    pat <= 8'h80;
    wr8(8'h1D, 8'h80);
    for (k = 0; k < 200 && n_restart == 0; k++) @(posedge clk);
    lim(k, 200);
    chk(n_reload, 1);
    chk(n_restart, 1);
    chk(pass_enable, 1'b1);
    rd8(8'h1D, 8'h00);
    rcfg <= 1'b0;
    wr8(8'h1D, 8'h80);
    repeat (40) @(posedge clk);
    chk(n_reload, 2);
    chk(n_restart, 1);
    end_sim();
  end
endmodule : tb_adc_control_status_regs
`default_nettype wire
